// file: tb/mstmon_meas_model.sv
/*
  Phase current source standing in for the RMS measurement stage.
  Assumes the bench sets the level of phases 1 and 2 and of phase 3.
*/
`timescale 1ns/10ps
module mstmon_meas_model (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        slow,
  input  wire logic [15:0] lvl,
  input  wire logic [15:0] lvl3,
  output logic             meas_valid,
  output logic [15:0]      i_ph1,
  output logic [15:0]      i_ph2,
  output logic [15:0]      i_ph3
);
  logic odd_q;
  logic v;
  // slow mode samples every other clock, so the monitor must not
  // rely on a sample every edge
  assign v = !slow || odd_q;
  // between samples the words are inverted, never a stale valid value
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      odd_q      <= 1'b0;
      meas_valid <= 1'b0;
      i_ph1      <= 16'h0000;
      i_ph2      <= 16'h0000;
      i_ph3      <= 16'h0000;
    end else begin
      odd_q      <= ~odd_q;
      meas_valid <= v;
      i_ph1      <= v ? lvl : ~lvl;
      i_ph2      <= v ? lvl : ~lvl;
      i_ph3      <= v ? lvl3 : ~lvl3;
    end
  end
endmodule : mstmon_meas_model

// file: tb/test_motor_status_monitor.sv
/*
  Self-checking bench of the motor status monitor with a state model.
  Assumes the measurement model drives the phase currents.
*/
`timescale 1ns/10ps
`include "mstmon_defs.svh"
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED at %0t: %s", $time, m); end end
module test_motor_status_monitor;
  localparam int NOLD = 100, SDET = 600, LMAX = 2000, OVL = 900;
  localparam int NOMI = 400;
  logic core_clk, rst_b, meas_valid, slow, irq_q;
  logic [15:0] i_ph1, i_ph2, i_ph3, lvl, lvl3;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [6:0]  flags_q;
  int n_errors, checked, st, c_st, c_su, c_sp, nom, fac, hi;

  mstmon_top dut (.core_clk, .rst_b, .meas_valid, .i_ph1, .i_ph2, .i_ph3,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .flags_q, .irq_q);
  mstmon_meas_model meas (.core_clk, .rst_b, .slow, .lvl, .lvl3,
    .meas_valid, .i_ph1, .i_ph2, .i_ph3);

  // free-running 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task end_of_test;
    if (n_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task time_out;
    n_errors++;
    $display("CHECK FAILED at %0t: wait limit reached", $time);
    end_of_test();
  endtask : time_out

  // both channels offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 50) time_out();
  endtask : wr

  task rdreg(input logic [7:0] a);
    int n;
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50) time_out();
  endtask : rdreg

  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    rdreg(a);
    `CHK(resp, 2'h0, "read response")
    `CHK(rd, e, "register value")
  endtask : rd_chk

  // model step: new levels, next state, counters and expected flags
  task apply(input int h, input int lo);
    int mx, mn, k;
    logic [5:0] e;
    mx = h > lo ? h : lo;
    mn = h < lo ? h : lo;
    nom = NOMI * fac / 256;
    if (st == 0 && mx > SDET && mx > NOLD) begin
      st = 1;
      c_st++;
    end else if (st != 0 && mx < NOLD) begin
      st = 0;
      c_sp++;
    end else if (st == 1 && mx < OVL) begin
      st = 2;
      c_su++;
    end
    e = {st != 0 && mn < NOLD && mx >= NOLD, st == 2 && mx > OVL,
         st == 2 && mx > nom && mx <= OVL,
         st == 2 && mx >= NOLD && mx <= nom, st == 2, st == 1};
    lvl  <= h[15:0];
    lvl3 <= lo[15:0];
    for (k = 0; k < 20 && flags_q[6:1] !== e; k++) @(posedge core_clk);
    `CHK(flags_q[6:1], e, "flag state")
  endtask : apply

  initial begin
    {rst_b, slow, lvl, lvl3, s_axi_awaddr, s_axi_awvalid} = '0;
    {s_axi_wdata, s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    {n_errors, checked, st, c_st, c_su, c_sp} = '0;
    fac = 256;
    hi = $urandom(41736);
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    rd_chk(`MSTMON_A_START_CNT, 32'h0000_0000);
    rd_chk(`MSTMON_A_RUN_MS, 32'h0000_0000);
    rd_chk(`MSTMON_A_FACTOR, 32'h0000_0100);
    rd_chk(`MSTMON_A_OVLMAX, 32'h0000_FFFF);
    wr(`MSTMON_A_NOLOAD, 32'(NOLD));
    wr(`MSTMON_A_STARTDET, 32'(SDET));
    wr(`MSTMON_A_LOCKMAX, 32'(LMAX));
    wr(`MSTMON_A_OVLMAX, 32'(OVL));
    wr(`MSTMON_A_NOMINAL, 32'(NOMI));
    rd_chk(`MSTMON_A_LOCKMAX, 32'(LMAX));
    wr(`MSTMON_A_FLAGS, 32'h0000_007F);
    `CHK(resp, 2'h2, "read-only write")
    rdreg(8'h80);
    `CHK({resp, rd}, {2'h2, 32'h0}, "unmapped read")
    wr(`MSTMON_A_CTRL, 32'h0000_0002);
    wr(`MSTMON_A_IRQ_MASK, 32'h0000_0002);
    apply($urandom_range(NOLD - 1, 0), $urandom_range(NOLD - 1, 0));
    // stays starting exactly at the overload limit
    apply(OVL, OVL);
    `CHK(flags_q[0], 1'b0, "stopped flag while starting")
    `CHK(irq_q, 1'b1, "event raises irq")
    wr(`MSTMON_A_IRQ_MASK, 32'h0000_0000);
    repeat (3) @(posedge core_clk);
    `CHK(irq_q, 1'b0, "masked irq")
    wr(`MSTMON_A_IRQ_MASK, 32'h0000_0002);
    repeat (3) @(posedge core_clk);
    `CHK(irq_q, 1'b1, "unmasked irq")
    wr(`MSTMON_A_IRQ_STAT, 32'h0000_0002);
    rd_chk(`MSTMON_A_IRQ_STAT, 32'h0000_0000);
    `CHK(irq_q, 1'b0, "cleared irq")
    repeat (30000) @(posedge core_clk);
    hi = $urandom_range(399, 201);
    apply(hi, hi);
    rd_chk(`MSTMON_A_IRQ_STAT, 32'h0000_0002);
    wr(`MSTMON_A_IRQ_STAT, 32'h0000_0002);
    // half factor moves the same current above the scaled nominal
    wr(`MSTMON_A_FACTOR, 32'h0000_0080);
    fac = 128;
    apply(hi, hi);
    wr(`MSTMON_A_FACTOR, 32'h0000_0100);
    fac = 256;
    apply(hi, hi);
    hi = $urandom_range(OVL, NOMI + 1);
    apply(hi, hi);
    slow <= 1'b1;
    hi = $urandom_range(LMAX - 1, OVL + 1);
    apply(hi, hi);
    slow <= 1'b0;
    apply(hi, $urandom_range(NOLD - 1, 0));
    apply(300, $urandom_range(NOLD - 1, 0));
    repeat (30000) @(posedge core_clk);
    apply($urandom_range(NOLD - 1, 0), 0);
    // the low window has only just begun, so the stopped flag stays low
    `CHK(flags_q[0], 1'b0, "stopped flag before window")
    rd_chk(`MSTMON_A_START_CNT, 32'(c_st));
    rd_chk(`MSTMON_A_SUCC_CNT, 32'(c_su));
    rd_chk(`MSTMON_A_STOP_CNT, 32'(c_sp));
    rdreg(`MSTMON_A_RUN_MS);
    `CHK(rd != 0, 1'b1, "run time")
    rdreg(`MSTMON_A_STRT_MS);
    `CHK(rd != 0, 1'b1, "start time")
    rdreg(`MSTMON_A_LAST_STOP);
    `CHK(rd != 0, 1'b1, "last stop")
    wr(`MSTMON_A_CTRL, 32'h8000_0002);
    rd_chk(`MSTMON_A_START_CNT, 32'h0000_0000);
    rd_chk(`MSTMON_A_STOP_CNT, 32'h0000_0000);
    end_of_test();
  end
endmodule : test_motor_status_monitor

// file: verilog/mstmon_acc.sv
/*
  Saturating event/time counter. Assumes a synchronous one-cycle increment
  and a synchronous clear from the same clock domain.
*/
`timescale 1ns/10ps
module mstmon_acc (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        inc,
  input  wire logic        clr,
  output logic      [31:0] count_q
);
  logic [31:0] count_d;

  // saturate rather than wrap so a long history never reads small
  always_comb begin
    count_d = count_q;
    if (clr) begin
      count_d = 32'h0000_0000;
    end else if (inc && count_q != 32'hFFFF_FFFF) begin
      count_d = count_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= 32'h0000_0000;
    end else begin
      count_q <= count_d;
    end
  end
endmodule : mstmon_acc

// file: verilog/mstmon_defs.svh
/*
  Constants of the motor status monitor: register offsets, field positions,
  reset values and timing counts. Assumes a 25 MHz core clock.
*/
`ifndef MSTMON_DEFS_SVH
`define MSTMON_DEFS_SVH

`define MSTMON_CLK_HZ        25000000
`define MSTMON_WIN_MS        10
`define MSTMON_WIN_CYC       ((`MSTMON_CLK_HZ / 1000) * `MSTMON_WIN_MS)
`define MSTMON_TICK_CYC      (`MSTMON_CLK_HZ / 1000)

// register byte offsets
`define MSTMON_A_CTRL        8'h00
`define MSTMON_A_NOLOAD      8'h04
`define MSTMON_A_STARTDET    8'h08
`define MSTMON_A_LOCKMAX     8'h0C
`define MSTMON_A_OVLMAX      8'h10
`define MSTMON_A_NOMINAL     8'h14
`define MSTMON_A_FACTOR      8'h18
`define MSTMON_A_FLAGS       8'h1C
`define MSTMON_A_IRQ_STAT    8'h20
`define MSTMON_A_IRQ_MASK    8'h24
`define MSTMON_A_START_CNT   8'h28
`define MSTMON_A_SUCC_CNT    8'h2C
`define MSTMON_A_STOP_CNT    8'h30
`define MSTMON_A_RUN_MS      8'h34
`define MSTMON_A_STRT_MS     8'h38
`define MSTMON_A_STOP_MS     8'h3C
`define MSTMON_A_LAST_STOP   8'h40
`define MSTMON_A_TIME_MS     8'h44

// flag bit positions
`define MSTMON_F_STOP        0
`define MSTMON_F_START       1
`define MSTMON_F_RUN         2
`define MSTMON_F_NORM        3
`define MSTMON_F_OVL         4
`define MSTMON_F_STALL       5
`define MSTMON_F_MISS        6
`define MSTMON_NFLAG         7

`define MSTMON_FACTOR_RST    16'h0100
`define MSTMON_CTRL_RST      32'h0000_0000
`endif

// file: verilog/mstmon_pkg.sv
/*
  Types of the motor status monitor. Assumes nothing of its surroundings.
*/
package mstmon_pkg;
  typedef enum logic [1:0] {
    STOPPED,
    STARTING,
    RUNNING
  } mstmon_state_type;
endpackage : mstmon_pkg

// file: verilog/mstmon_top.sv
/*
  Motor status monitor: classifies the motor state from three phase RMS
  currents, keeps counters and time accumulators, AXI4-Lite registers and
  an interrupt. Assumes RMS words arrive from same-clock logic with a
  one-cycle sample strobe once per protection cycle.
*/
`timescale 1ns/10ps
`include "mstmon_defs.svh"
module mstmon_top (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        meas_valid,
  input  wire logic [15:0] i_ph1,
  input  wire logic [15:0] i_ph2,
  input  wire logic [15:0] i_ph3,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [6:0]       flags_q,
  output logic             irq_q
);
  localparam int NF = `MSTMON_NFLAG;
  localparam int WIN = `MSTMON_WIN_CYC;
  localparam int TICK = `MSTMON_TICK_CYC;

  mstmon_pkg::mstmon_state_type state_q, state_d;
  logic [15:0] noload_q, startdet_q, lockmax_q, ovlmax_q, nominal_q;
  logic [15:0] factor_q;
  logic [NF-1:0] ev_en_q, mask_q, stat_q, flags_d, stat_d;
  logic [18:0] low_cnt_q, low_cnt_d, rise_cnt_q, rise_cnt_d;
  logic        rise_arm_q, rise_arm_d;
  logic [15:0] tick_q, tick_d;
  logic [31:0] last_stop_q, last_stop_d;
  logic [15:0] imax, imin;
  logic [31:0] nom_scaled;
  logic        ms_tick, ev_start, ev_succ, ev_stop;
  logic        is_low, all_low, is_sd;
  logic [31:0] start_cnt, succ_cnt, stop_cnt, run_ms, strt_ms, stop_ms;
  logic [31:0] time_ms;
  logic        clr_cnt;

  // largest and smallest phase current
  always_comb begin
    imax = i_ph1;
    imin = i_ph1;
    if (i_ph2 > imax) imax = i_ph2;
    if (i_ph3 > imax) imax = i_ph3;
    if (i_ph2 < imin) imin = i_ph2;
    if (i_ph3 < imin) imin = i_ph3;
  end

  // nominal scaled by factor
  // factor is 8.8 fixed point: service times ambient, set by software
  assign nom_scaled = (32'(nominal_q) * 32'(factor_q)) >> 8;
  assign is_low  = imax < noload_q;
  assign all_low = is_low;
  assign is_sd   = imax > startdet_q && imax > noload_q;

  // millisecond tick for the time accumulators
  assign ms_tick = (tick_q == 16'(TICK - 1));
  always_comb begin
    tick_d = ms_tick ? 16'h0000 : tick_q + 16'h0001;
  end

  always_comb begin
    state_d     = state_q;
    low_cnt_d   = low_cnt_q;
    rise_cnt_d  = rise_cnt_q;
    rise_arm_d  = rise_arm_q;
    last_stop_d = last_stop_q;
    ev_start    = 1'b0;
    ev_succ     = 1'b0;
    ev_stop     = 1'b0;
    if (meas_valid) begin
      low_cnt_d = all_low ? ((low_cnt_q > 19'(WIN)) ? low_cnt_q
                                                    : low_cnt_q + 19'h1)
                          : 19'h0;
      if (all_low) begin
        rise_arm_d = 1'b1;
        rise_cnt_d = 19'h0;
      end else if (rise_arm_q && rise_cnt_q <= 19'(WIN)) begin
        rise_cnt_d = rise_cnt_q + 19'h1;
      end else begin
        rise_arm_d = 1'b0;
      end
      case (state_q)
        mstmon_pkg::STOPPED: begin
          if (is_sd && rise_arm_q && rise_cnt_q <= 19'(WIN)) begin
            state_d    = mstmon_pkg::STARTING;
            ev_start   = 1'b1;
            rise_arm_d = 1'b0;
          end
        end
        mstmon_pkg::STARTING: begin
          if (is_low) begin
            state_d = mstmon_pkg::STOPPED;
            ev_stop = 1'b1;
            last_stop_d = time_ms;
          end else if (imax < ovlmax_q) begin
            state_d = mstmon_pkg::RUNNING;
            ev_succ = 1'b1;
          end
        end
        default: begin
          if (is_low) begin
            state_d = mstmon_pkg::STOPPED;
            ev_stop = 1'b1;
            last_stop_d = time_ms;
          end
        end
      endcase
    end
  end

  // output flags from the next state
  always_comb begin
    flags_d = '0;
    flags_d[`MSTMON_F_START] = state_d == mstmon_pkg::STARTING;
    flags_d[`MSTMON_F_RUN]   = state_d == mstmon_pkg::RUNNING;
    flags_d[`MSTMON_F_STOP]  = state_d == mstmon_pkg::STOPPED &&
                               low_cnt_d > 19'(WIN);
    if (state_d == mstmon_pkg::RUNNING) begin
      flags_d[`MSTMON_F_NORM] = imax >= noload_q &&
                                32'(imax) <= nom_scaled;
      flags_d[`MSTMON_F_OVL]  = 32'(imax) > nom_scaled &&
                                imax <= ovlmax_q;
      flags_d[`MSTMON_F_STALL] = imax > ovlmax_q;
    end
    flags_d[`MSTMON_F_MISS] = state_d != mstmon_pkg::STOPPED &&
                              imin < noload_q && !is_low;
    if (!meas_valid) flags_d = flags_q;
  end

  // flag changes raise enabled events, set wins over clear
  always_comb begin
    stat_d = stat_q;
    if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
        s_axi_awaddr == `MSTMON_A_IRQ_STAT) begin
      stat_d = stat_q & ~s_axi_wdata[NF-1:0];
    end
    stat_d = stat_d | ((flags_d ^ flags_q) & ev_en_q);
  end

  // state and status registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q     <= mstmon_pkg::STOPPED;
      low_cnt_q   <= 19'h0;
      rise_cnt_q  <= 19'h0;
      rise_arm_q  <= 1'b0;
      tick_q      <= 16'h0000;
      last_stop_q <= 32'h0000_0000;
      flags_q     <= 7'h00;
      stat_q      <= 7'h00;
      irq_q       <= 1'b0;
    end else begin
      state_q     <= state_d;
      low_cnt_q   <= low_cnt_d;
      rise_cnt_q  <= rise_cnt_d;
      rise_arm_q  <= rise_arm_d;
      tick_q      <= tick_d;
      last_stop_q <= last_stop_d;
      flags_q     <= flags_d;
      stat_q      <= stat_d;
      irq_q       <= |(stat_d & mask_q);
    end
  end

  mstmon_acc u_start (.core_clk(core_clk), .rst_b(rst_b), .inc(ev_start),
                      .clr(clr_cnt), .count_q(start_cnt));
  mstmon_acc u_succ  (.core_clk(core_clk), .rst_b(rst_b), .inc(ev_succ),
                      .clr(clr_cnt), .count_q(succ_cnt));
  mstmon_acc u_stop  (.core_clk(core_clk), .rst_b(rst_b), .inc(ev_stop),
                      .clr(clr_cnt), .count_q(stop_cnt));
  mstmon_acc u_run   (.core_clk(core_clk), .rst_b(rst_b),
                      .inc(ms_tick && state_q == mstmon_pkg::RUNNING),
                      .clr(clr_cnt), .count_q(run_ms));
  mstmon_acc u_strt  (.core_clk(core_clk), .rst_b(rst_b),
                      .inc(ms_tick && state_q == mstmon_pkg::STARTING),
                      .clr(clr_cnt), .count_q(strt_ms));
  mstmon_acc u_stpt  (.core_clk(core_clk), .rst_b(rst_b),
                      .inc(ms_tick && state_q == mstmon_pkg::STOPPED),
                      .clr(clr_cnt), .count_q(stop_ms));
  mstmon_acc u_time  (.core_clk(core_clk), .rst_b(rst_b), .inc(ms_tick),
                      .clr(1'b0), .count_q(time_ms));

  // AXI4-Lite write: address and data taken together, one cycle
  logic        wr_go, rd_go;
  logic [31:0] rdata_d;
  logic        rd_ok;
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && !s_axi_rvalid;
  assign clr_cnt = wr_go && s_axi_awaddr == `MSTMON_A_CTRL &&
                   s_axi_wdata[31];

  // read decode; unmapped addresses answer slverr
  always_comb begin
    rdata_d = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (s_axi_araddr == `MSTMON_A_CTRL) rdata_d = {25'h0, ev_en_q};
    else if (s_axi_araddr == `MSTMON_A_NOLOAD) rdata_d = {16'h0, noload_q};
    else if (s_axi_araddr == `MSTMON_A_STARTDET)
      rdata_d = {16'h0, startdet_q};
    else if (s_axi_araddr == `MSTMON_A_LOCKMAX) rdata_d = {16'h0, lockmax_q};
    else if (s_axi_araddr == `MSTMON_A_OVLMAX) rdata_d = {16'h0, ovlmax_q};
    else if (s_axi_araddr == `MSTMON_A_NOMINAL) rdata_d = {16'h0, nominal_q};
    else if (s_axi_araddr == `MSTMON_A_FACTOR) rdata_d = {16'h0, factor_q};
    else if (s_axi_araddr == `MSTMON_A_FLAGS) rdata_d = {25'h0, flags_q};
    else if (s_axi_araddr == `MSTMON_A_IRQ_STAT) rdata_d = {25'h0, stat_q};
    else if (s_axi_araddr == `MSTMON_A_IRQ_MASK) rdata_d = {25'h0, mask_q};
    else if (s_axi_araddr == `MSTMON_A_START_CNT) rdata_d = start_cnt;
    else if (s_axi_araddr == `MSTMON_A_SUCC_CNT) rdata_d = succ_cnt;
    else if (s_axi_araddr == `MSTMON_A_STOP_CNT) rdata_d = stop_cnt;
    else if (s_axi_araddr == `MSTMON_A_RUN_MS) rdata_d = run_ms;
    else if (s_axi_araddr == `MSTMON_A_STRT_MS) rdata_d = strt_ms;
    else if (s_axi_araddr == `MSTMON_A_STOP_MS) rdata_d = stop_ms;
    else if (s_axi_araddr == `MSTMON_A_LAST_STOP) rdata_d = last_stop_q;
    else if (s_axi_araddr == `MSTMON_A_TIME_MS) rdata_d = time_ms;
    else rd_ok = 1'b0;
  end

  // bus registers; lockmax is held for software only
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      noload_q <= 16'h0000;
      startdet_q <= 16'h0000;
      lockmax_q <= 16'h0000;
      ovlmax_q <= 16'hFFFF;
      nominal_q <= 16'h0000;
      factor_q <= `MSTMON_FACTOR_RST;
      ev_en_q <= 7'h00;
      mask_q <= 7'h00;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      s_axi_arready <= rd_go;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        if (s_axi_awaddr == `MSTMON_A_CTRL) ev_en_q <= s_axi_wdata[6:0];
        else if (s_axi_awaddr == `MSTMON_A_NOLOAD)
          noload_q <= s_axi_wdata[15:0];
        else if (s_axi_awaddr == `MSTMON_A_STARTDET)
          startdet_q <= s_axi_wdata[15:0];
        else if (s_axi_awaddr == `MSTMON_A_LOCKMAX)
          lockmax_q <= s_axi_wdata[15:0];
        else if (s_axi_awaddr == `MSTMON_A_OVLMAX)
          ovlmax_q <= s_axi_wdata[15:0];
        else if (s_axi_awaddr == `MSTMON_A_NOMINAL)
          nominal_q <= s_axi_wdata[15:0];
        else if (s_axi_awaddr == `MSTMON_A_FACTOR)
          factor_q <= s_axi_wdata[15:0];
        else if (s_axi_awaddr == `MSTMON_A_IRQ_MASK)
          mask_q <= s_axi_wdata[6:0];
        else if (s_axi_awaddr != `MSTMON_A_IRQ_STAT)
          s_axi_bresp <= 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_d;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  chk_one_state: assert property (@(posedge core_clk) disable iff (!rst_b)
    $onehot({flags_q[2:1], state_q == mstmon_pkg::STOPPED}))
    else $error("state flags not one-hot");
  chk_start_count: assert property (@(posedge core_clk) disable iff (!rst_b)
    ev_start && !clr_cnt && start_cnt != 32'hFFFF_FFFF |=>
    start_cnt == $past(start_cnt) + 32'h1)
    else $error("start counter missed");
  chk_start_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
    ev_start |=> flags_q[`MSTMON_F_START])
    else $error("starting flag absent");
  chk_run_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
    ev_succ |=> flags_q[`MSTMON_F_RUN] && !flags_q[`MSTMON_F_START])
    else $error("running flag absent");
  chk_miss_phase: assert property (@(posedge core_clk) disable iff (!rst_b)
    flags_q[`MSTMON_F_MISS] |-> state_q != mstmon_pkg::STOPPED)
    else $error("missing phase while stopped");
  chk_stall_run: assert property (@(posedge core_clk) disable iff (!rst_b)
    flags_q[`MSTMON_F_STALL] |-> flags_q[`MSTMON_F_RUN] &&
    !flags_q[`MSTMON_F_OVL])
    else $error("stalled flag inconsistent");
  chk_stop_state: assert property (@(posedge core_clk) disable iff (!rst_b)
    ev_stop |=> state_q == mstmon_pkg::STOPPED &&
    last_stop_q == $past(time_ms))
    else $error("stop not recorded");
  chk_irq_level: assert property (@(posedge core_clk) disable iff (!rst_b)
    ##1 irq_q == |($past(stat_d) & $past(mask_q)))
    else $error("irq level mismatch");
  // stopped flag needs long low time
  chk_stop_delay: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(flags_q[`MSTMON_F_STOP]) |-> low_cnt_q > 19'(WIN))
    else $error("stopped flag too early");
  cov_start: cover property (@(posedge core_clk) ev_start);
  cov_run: cover property (@(posedge core_clk) ev_succ);
  cov_stop: cover property (@(posedge core_clk) ev_stop);
  cov_irq: cover property (@(posedge core_clk) $rose(irq_q));
endmodule : mstmon_top
